// ---- synth_prog_pkg.sv ----
// constants, register map and encodings shared by the divider programmer
// assumes frequencies in whole hertz; every permitted step size is a whole hertz
package synth_prog_pkg;
	// register byte addresses (word aligned)
	localparam logic [5:0] A_CTRL     = 6'h00;
	localparam logic [5:0] A_CMD      = 6'h04;
	localparam logic [5:0] A_PRE_LO   = 6'h08;
	localparam logic [5:0] A_PRE_MD   = 6'h0c;
	localparam logic [5:0] A_PRE_HI   = 6'h10;
	localparam logic [5:0] A_FREQ_REQ = 6'h14;
	localparam logic [5:0] A_REF_REQ  = 6'h18;
	localparam logic [5:0] A_SP_REQ   = 6'h1c;
	localparam logic [5:0] A_STATUS   = 6'h20;
	localparam logic [5:0] A_IRQ_ST   = 6'h24;
	localparam logic [5:0] A_IRQ_MASK = 6'h28;
	localparam logic [5:0] A_OUT_FREQ = 6'h2c;
	localparam logic [5:0] A_COUNTS   = 6'h30;
	localparam logic [5:0] A_REF_CUR  = 6'h34;
	localparam logic [5:0] A_SP_CUR   = 6'h38;
	// commands written to A_CMD
	localparam logic [2:0] C_LOW  = 3'h1;
	localparam logic [2:0] C_MED  = 3'h2;
	localparam logic [2:0] C_HIGH = 3'h3;
	localparam logic [2:0] C_UP   = 3'h4;
	localparam logic [2:0] C_DOWN = 3'h5;
	localparam logic [2:0] C_FREQ = 3'h6;
	localparam logic [2:0] C_REF  = 3'h7;
	// error codes
	localparam logic [2:0] E_NONE    = 3'h0;
	localparam logic [2:0] E_MULT    = 3'h1;
	localparam logic [2:0] E_LOW     = 3'h2;
	localparam logic [2:0] E_HIGH    = 3'h3;
	localparam logic [2:0] E_SPACING = 3'h4;
	localparam logic [2:0] E_REF_RAT = 3'h5;
	localparam logic [2:0] E_REF_ODD = 3'h6;
	// board variants
	localparam logic [1:0] V_SINGLE_100K = 2'h0;
	localparam logic [1:0] V_SINGLE_200K = 2'h1;
	localparam logic [1:0] V_DUAL        = 2'h2;
	// divider limits
	localparam logic [31:0] TOTAL_MIN  = 32'd4032;
	localparam logic [31:0] TOTAL_MAX  = 32'd262143;
	localparam logic [31:0] REF_RATIO  = 32'd8191;
	localparam int          PRESCALE_W = 6;    // prescale of 64
	localparam logic [31:0] SP_MAX     = 32'd2_000_000;
	localparam logic [31:0] SP_MAX_DUAL = 32'd1_000_000;
	// defaults per variant, hertz
	localparam logic [31:0] S1_LO = 32'd733_000_000;
	localparam logic [31:0] S1_MD = 32'd738_000_000;
	localparam logic [31:0] S1_HI = 32'd743_000_000;
	localparam logic [31:0] S2_LO = 32'd1_466_000_000;
	localparam logic [31:0] S2_MD = 32'd1_476_000_000;
	localparam logic [31:0] S2_HI = 32'd1_486_000_000;
	localparam logic [31:0] D_LO  = 32'd45_000_000;
	localparam logic [31:0] D_MD  = 32'd60_000_000;
	localparam logic [31:0] D_HI  = 32'd75_000_000;
	localparam logic [31:0] S_REF = 32'd14_400_000;
	localparam logic [31:0] D_REF = 32'd10_010_000;
	localparam logic [31:0] S1_SP = 32'd100_000;
	localparam logic [31:0] S2_SP = 32'd200_000;
	localparam logic [31:0] D_SP  = 32'd10_000;
	localparam logic [5:0]  DIV_LAST = 6'd31;
	// one-hot sequencer states
	typedef enum logic [4:0] {
		S_IDLE  = 5'b00001,
		S_DIV   = 5'b00010,
		S_CHECK = 5'b00100,
		S_WREF  = 5'b01000,
		S_WMAIN = 5'b10000
	} seq_t;
endpackage

// ---- synth_prog.sv ----
// synthesizer divider programmer: presets, stepping, checks and register writes
// assumes one clock, synchronous reset, an avalon-mm master and a synthesizer
// register port that accepts one write strobe per cycle
`timescale 1ns/1ns
module synth_prog (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst_n,
	// board variant strap, caught during reset
	input  wire logic [1:0]  board_variant,
	// avalon-mm slave
	input  wire logic [5:0]  address,
	input  wire logic        read,
	input  wire logic        write,
	input  wire logic [31:0] writedata,
	output logic      [31:0] readdata,
	output logic             waitrequest,
	// interrupt
	output logic             irq,
	// synthesizer register port
	output logic             syn_wr,
	output logic             syn_ref_sel,
	output logic      [1:0]  syn_loop_mask,
	output logic      [11:0] main_divide_count,
	output logic      [5:0]  swallow_count,
	output logic      [12:0] reference_divide_count
);
	// whole state of the block
	typedef struct packed {
		synth_prog_pkg::seq_t seq;        // sequencer
		logic [2:0]        op;            // running command
		logic [1:0]        mask;          // loops addressed
		logic              phase_ref;     // dividing for reference
		logic [1:0]        variant;       // captured strap
		logic [1:0][31:0]  freq;          // programmed output per loop
		logic [1:0][17:0]  total;         // programmed divide per loop
		logic [31:0]       pre_lo, pre_md, pre_hi; // presets
		logic [31:0]       freq_req;      // requested output
		logic [31:0]       ref_req;       // requested reference
		logic [31:0]       sp_req;        // requested spacing
		logic [31:0]       ref_cur;       // active reference
		logic [31:0]       sp_cur;        // active spacing
		logic              dual_mode;     // dual-loop operation
		logic              loop_sel;      // selected loop
		logic [1:0]        irq_st;        // bit0 done, bit1 error
		logic [1:0]        irq_mask;
		logic [2:0]        err;           // last error code
		logic              ack;           // bus answer cycle
		logic [31:0]       rdata;
		logic [32:0]       rem;           // divider remainder
		logic [31:0]       quo;           // divider quotient
		logic [31:0]       dvs;           // divider divisor
		logic [5:0]        cnt;           // divider bit count
		logic [31:0]       target;        // frequency being set
		logic              syn_wr;
		logic              syn_ref;
		logic [1:0]        syn_mask;
		logic [11:0]       syn_main;
		logic [5:0]        syn_swal;
		logic [12:0]       syn_refc;
	} state_t;
	state_t st_r;   // registered state
	state_t st_nxt; // next state
	// zero means an empty entry; keep what is held
	function automatic logic [31:0] keep_or(input logic [31:0] old_v, input logic [31:0] new_v);
		keep_or = (new_v == 32'h0) ? old_v : new_v;
	endfunction
	// reset image, chosen by the strap
	function automatic state_t reset_image(input logic [1:0] v);
		state_t s;
		logic   dv; // dual-loop board
		logic   wv; // single board, wide spacing
		s = '0;
		dv = (v == synth_prog_pkg::V_DUAL);
		wv = (v == synth_prog_pkg::V_SINGLE_200K);
		s.seq = synth_prog_pkg::S_IDLE;
		s.variant = v;
		s.pre_lo = dv ? synth_prog_pkg::D_LO : wv ? synth_prog_pkg::S2_LO : synth_prog_pkg::S1_LO;
		s.pre_md = dv ? synth_prog_pkg::D_MD : wv ? synth_prog_pkg::S2_MD : synth_prog_pkg::S1_MD;
		s.pre_hi = dv ? synth_prog_pkg::D_HI : wv ? synth_prog_pkg::S2_HI : synth_prog_pkg::S1_HI;
		s.ref_cur = dv ? synth_prog_pkg::D_REF : synth_prog_pkg::S_REF;
		s.sp_cur = dv ? synth_prog_pkg::D_SP : wv ? synth_prog_pkg::S2_SP : synth_prog_pkg::S1_SP;
		// start on the medium preset, counts matching it
		s.freq = {2{s.pre_md}};
		s.total = {2{18'(s.pre_md / s.sp_cur)}};
		s.ref_req = s.ref_cur;
		s.sp_req = s.sp_cur;
		s.freq_req = s.pre_md;
		return s;
	endfunction
	// combinational helpers
	logic        acc;       // first cycle of a bus request
	logic        wr_take;   // write takes effect
	logic        rd_take;   // read completes
	logic        bidx;      // loop used as base
	logic [1:0]  lmask;     // loops a command addresses
	logic [31:0] sp_lim;    // widest spacing allowed
	logic [32:0] rem_sh;    // shifted remainder
	logic [1:0]  ev;        // events this cycle
	logic [31:0] rmux;      // read multiplexer
	// next-state logic
	always_comb begin
		st_nxt = st_r;
		st_nxt.syn_wr = 1'b0;
		ev = 2'b00;
		acc = (read || write) && !st_r.ack;
		wr_take = write && st_r.ack;
		rd_take = read && st_r.ack;
		st_nxt.ack = acc;
		// base loop and addressed loops
		if (st_r.variant == synth_prog_pkg::V_DUAL && st_r.dual_mode) begin
			bidx = st_r.loop_sel;
			lmask = st_r.loop_sel ? 2'b10 : 2'b01;
		end else if (st_r.variant == synth_prog_pkg::V_DUAL) begin
			bidx = 1'b0;
			lmask = 2'b11;
		end else begin
			bidx = 1'b0;
			lmask = 2'b01;
		end
		sp_lim = (st_r.variant == synth_prog_pkg::V_DUAL) ? synth_prog_pkg::SP_MAX_DUAL : synth_prog_pkg::SP_MAX;
		rem_sh = {st_r.rem[31:0], st_r.quo[31]};
		// read data latched in the first cycle
		unique case (address)
			synth_prog_pkg::A_CTRL:     rmux = {30'h0, st_r.loop_sel, st_r.dual_mode};
			synth_prog_pkg::A_PRE_LO:   rmux = st_r.pre_lo;
			synth_prog_pkg::A_PRE_MD:   rmux = st_r.pre_md;
			synth_prog_pkg::A_PRE_HI:   rmux = st_r.pre_hi;
			synth_prog_pkg::A_FREQ_REQ: rmux = st_r.freq_req;
			synth_prog_pkg::A_REF_REQ:  rmux = st_r.ref_req;
			synth_prog_pkg::A_SP_REQ:   rmux = st_r.sp_req;
			synth_prog_pkg::A_STATUS:   rmux = {26'h0, st_r.variant, st_r.seq != synth_prog_pkg::S_IDLE, st_r.err};
			synth_prog_pkg::A_IRQ_ST:   rmux = {30'h0, st_r.irq_st};
			synth_prog_pkg::A_IRQ_MASK: rmux = {30'h0, st_r.irq_mask};
			synth_prog_pkg::A_OUT_FREQ: rmux = st_r.freq[bidx];
			synth_prog_pkg::A_COUNTS:   rmux = {14'h0, st_r.total[bidx]};
			synth_prog_pkg::A_REF_CUR:  rmux = st_r.ref_cur;
			synth_prog_pkg::A_SP_CUR:   rmux = st_r.sp_cur;
			default:                    rmux = 32'h0; // unmapped reads zero
		endcase
		if (acc) st_nxt.rdata = rmux;
		// register writes; preset edits never reach the synthesizer
		if (wr_take) begin
			unique case (address)
				synth_prog_pkg::A_CTRL:     {st_nxt.loop_sel, st_nxt.dual_mode} = writedata[1:0];
				synth_prog_pkg::A_PRE_LO:   st_nxt.pre_lo = keep_or(st_r.pre_lo, writedata);
				synth_prog_pkg::A_PRE_MD:   st_nxt.pre_md = keep_or(st_r.pre_md, writedata);
				synth_prog_pkg::A_PRE_HI:   st_nxt.pre_hi = keep_or(st_r.pre_hi, writedata);
				synth_prog_pkg::A_FREQ_REQ: st_nxt.freq_req = keep_or(st_r.freq_req, writedata);
				synth_prog_pkg::A_REF_REQ:  st_nxt.ref_req = keep_or(st_r.ref_req, writedata);
				synth_prog_pkg::A_SP_REQ:   st_nxt.sp_req = keep_or(st_r.sp_req, writedata);
				synth_prog_pkg::A_IRQ_MASK: st_nxt.irq_mask = writedata[1:0];
				default: ;                  // others ignored
			endcase
		end
		// sequencer
		unique case (st_r.seq)
			synth_prog_pkg::S_IDLE: begin
				// commands while busy are dropped, so only idle starts one
				if (wr_take && address == synth_prog_pkg::A_CMD) begin
					st_nxt.op = writedata[2:0];
					st_nxt.mask = lmask;
					st_nxt.phase_ref = 1'b0;
					st_nxt.rem = '0;
					st_nxt.cnt = '0;
					st_nxt.dvs = st_r.sp_cur;
					st_nxt.seq = synth_prog_pkg::S_DIV;
					unique case (writedata[2:0])
						synth_prog_pkg::C_LOW:  st_nxt.target = st_r.pre_lo;
						synth_prog_pkg::C_MED:  st_nxt.target = st_r.pre_md;
						synth_prog_pkg::C_HIGH: st_nxt.target = st_r.pre_hi;
						synth_prog_pkg::C_FREQ: st_nxt.target = st_r.freq_req; // total range checked like the presets
						synth_prog_pkg::C_UP, synth_prog_pkg::C_DOWN: begin
							// step moves the total by one, output by one spacing
							st_nxt.seq = synth_prog_pkg::S_CHECK;
							if (writedata[2:0] == synth_prog_pkg::C_UP) begin
								st_nxt.target = st_r.freq[bidx] + st_r.sp_cur;
								st_nxt.quo = {14'h0, st_r.total[bidx]} + 32'h1;
							end else begin
								st_nxt.target = st_r.freq[bidx] - st_r.sp_cur;
								st_nxt.quo = {14'h0, st_r.total[bidx]} - 32'h1;
							end
						end
						synth_prog_pkg::C_REF: begin
							st_nxt.target = st_r.ref_req;
							st_nxt.dvs = st_r.sp_req;
							st_nxt.phase_ref = 1'b1;
							if (st_r.sp_req > sp_lim) begin
								st_nxt.err = synth_prog_pkg::E_SPACING;
								st_nxt.seq = synth_prog_pkg::S_IDLE;
								ev[1] = 1'b1;
							end
						end
						default: st_nxt.seq = synth_prog_pkg::S_IDLE; // unknown code
					endcase
					if (writedata[2:0] != synth_prog_pkg::C_UP && writedata[2:0] != synth_prog_pkg::C_DOWN) begin
						st_nxt.quo = st_nxt.target; // dividend is the value under test
					end
				end
			end
			synth_prog_pkg::S_DIV: begin
				// restoring division, one bit a cycle, exact in hertz
				if (rem_sh >= {1'b0, st_r.dvs}) begin
					st_nxt.rem = rem_sh - {1'b0, st_r.dvs};
					st_nxt.quo = {st_r.quo[30:0], 1'b1};
				end else begin
					st_nxt.rem = rem_sh;
					st_nxt.quo = {st_r.quo[30:0], 1'b0};
				end
				st_nxt.cnt = st_r.cnt + 6'h1;
				if (st_r.cnt == synth_prog_pkg::DIV_LAST) st_nxt.seq = synth_prog_pkg::S_CHECK;
			end
			synth_prog_pkg::S_CHECK: begin
				st_nxt.seq = synth_prog_pkg::S_IDLE;
				if (st_r.phase_ref) begin
					if (st_r.rem != 33'h0 || st_r.quo[0]) begin
						st_nxt.err = synth_prog_pkg::E_REF_ODD;
					end else if (st_r.quo >= synth_prog_pkg::REF_RATIO) begin
						st_nxt.err = synth_prog_pkg::E_REF_RAT;
					end else begin
						st_nxt.seq = synth_prog_pkg::S_WREF;
					end
				end else begin
					if (st_r.rem != 33'h0) begin
						st_nxt.err = synth_prog_pkg::E_MULT;
					end else if (st_r.quo > synth_prog_pkg::TOTAL_MAX) begin
						st_nxt.err = synth_prog_pkg::E_HIGH;
					end else if (st_r.quo < synth_prog_pkg::TOTAL_MIN &&
					             (st_r.quo >> synth_prog_pkg::PRESCALE_W) < {26'h0, st_r.quo[5:0]}) begin
						st_nxt.err = synth_prog_pkg::E_LOW;
					end else begin
						st_nxt.seq = synth_prog_pkg::S_WMAIN;
					end
				end
				if (st_nxt.seq == synth_prog_pkg::S_IDLE) ev[1] = 1'b1; // failed: no write follows
			end
			synth_prog_pkg::S_WREF: begin
				// reference divider goes out before the counts
				st_nxt.syn_wr = 1'b1;
				st_nxt.syn_ref = 1'b1;
				st_nxt.syn_mask = st_r.mask;
				st_nxt.syn_refc = st_r.quo[12:0];
				st_nxt.ref_cur = st_r.target;
				st_nxt.sp_cur = st_r.dvs;
				// recompute counts for the unchanged output
				st_nxt.target = st_r.freq[bidx];
				st_nxt.quo = st_r.freq[bidx];
				st_nxt.rem = '0;
				st_nxt.cnt = '0;
				st_nxt.phase_ref = 1'b0;
				st_nxt.seq = synth_prog_pkg::S_DIV;
			end
			synth_prog_pkg::S_WMAIN: begin
				// split total into main and swallow, prescale 64
				st_nxt.syn_wr = 1'b1;
				st_nxt.syn_ref = 1'b0;
				st_nxt.syn_mask = st_r.mask;
				st_nxt.syn_main = st_r.quo[17:synth_prog_pkg::PRESCALE_W];
				st_nxt.syn_swal = st_r.quo[synth_prog_pkg::PRESCALE_W-1:0];
				for (int i = 0; i < 2; i++) begin
					if (st_r.mask[i]) begin
						st_nxt.freq[i] = st_r.target;
						st_nxt.total[i] = st_r.quo[17:0];
					end
				end
				st_nxt.err = synth_prog_pkg::E_NONE;
				ev[0] = 1'b1;
				st_nxt.seq = synth_prog_pkg::S_IDLE;
			end
		endcase
		// sticky events; a new event beats the read clear
		st_nxt.irq_st = ((rd_take && address == synth_prog_pkg::A_IRQ_ST) ? 2'b00 : st_r.irq_st) | ev;
	end
	// state register with strap capture in reset
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			st_r <= reset_image(board_variant);
		end else begin
			st_r <= st_nxt;
		end
	end
	// outputs
	assign readdata = st_r.rdata;
	assign waitrequest = (read || write) && !st_r.ack;
	assign irq = |(st_r.irq_st & st_r.irq_mask);
	assign syn_wr = st_r.syn_wr;
	assign syn_ref_sel = st_r.syn_ref;
	assign syn_loop_mask = st_r.syn_mask;
	assign main_divide_count = st_r.syn_main;
	assign swallow_count = st_r.syn_swal;
	assign reference_divide_count = st_r.syn_refc;
	// assertion helpers
	logic [17:0] syn_total;
	assign syn_total = {st_r.syn_main, st_r.syn_swal};
	property p_preset_quiet;
		@(posedge clk) disable iff (!rst_n)
		(st_r.seq == synth_prog_pkg::S_IDLE && wr_take && address == synth_prog_pkg::A_PRE_LO) |=> ##1 !syn_wr;
	endproperty
	a_preset_quiet: assert property (p_preset_quiet) else $error("preset edit wrote synthesizer");
	property p_empty_keeps;
		@(posedge clk) disable iff (!rst_n)
		(wr_take && address == synth_prog_pkg::A_PRE_LO && writedata == 32'h0) |=> $stable(st_r.pre_lo);
	endproperty
	a_empty_keeps: assert property (p_empty_keeps) else $error("empty entry changed preset");
	property p_dual_defaults;
		@(posedge clk)
		(!rst_n && board_variant == synth_prog_pkg::V_DUAL) |=> (st_r.pre_lo == synth_prog_pkg::D_LO &&
		                                                        st_r.pre_hi == synth_prog_pkg::D_HI);
	endproperty
	a_dual_defaults: assert property (p_dual_defaults) else $error("dual presets wrong");
	property p_step_up;
		@(posedge clk) disable iff (!rst_n)
		(syn_wr && !syn_ref_sel && st_r.op == synth_prog_pkg::C_UP) |-> syn_total == $past(st_r.quo[17:0]) &&
		$past(st_r.quo) == $past(st_r.total[0], 3) + 32'h1 || $past(st_r.mask) != 2'b01;
	endproperty
	a_step_up: assert property (p_step_up) else $error("step up total wrong");
	property p_total_limits;
		@(posedge clk) disable iff (!rst_n)
		(syn_wr && !syn_ref_sel) |-> ({14'h0, syn_total} <= synth_prog_pkg::TOTAL_MAX) &&
		({14'h0, syn_total} >= synth_prog_pkg::TOTAL_MIN || {6'h0, main_divide_count} >= {12'h0, swallow_count});
	endproperty
	a_total_limits: assert property (p_total_limits) else $error("total divide out of limits");
	property p_mult_reject;
		@(posedge clk) disable iff (!rst_n)
		(st_r.seq == synth_prog_pkg::S_CHECK && !st_r.phase_ref && st_r.rem != 33'h0)
		|=> (st_r.err == synth_prog_pkg::E_MULT && st_r.irq_st[1]) ##1 !syn_wr;
	endproperty
	a_mult_reject: assert property (p_mult_reject) else $error("non-multiple not rejected");
	property p_spacing_limit;
		@(posedge clk) disable iff (!rst_n)
		(syn_wr && syn_ref_sel) |-> st_r.sp_cur <= sp_lim && !reference_divide_count[0];
	endproperty
	a_spacing_limit: assert property (p_spacing_limit) else $error("bad spacing programmed");
	property p_ref_then_main;
		@(posedge clk) disable iff (!rst_n)
		(syn_wr && syn_ref_sel) |-> ##[1:40] ((syn_wr && !syn_ref_sel) || st_r.irq_st[1]);
	endproperty
	a_ref_then_main: assert property (p_ref_then_main) else $error("counts not rewritten after reference");
	property p_error_no_write;
		@(posedge clk) disable iff (!rst_n)
		$rose(st_r.irq_st[1]) && st_r.err != synth_prog_pkg::E_NONE |-> !syn_wr ##1 !syn_wr;
	endproperty
	a_error_no_write: assert property (p_error_no_write) else $error("write despite failed check");
endmodule // synth_prog

// ---- synth_chip_model.sv ----
// far-side model: synthesizer register port, latches every strobe
// assumes counts are valid in the cycle syn_wr is high
`timescale 1ns/1ns
module synth_chip_model (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst_n,
	// register port
	input  wire logic        syn_wr,
	input  wire logic        syn_ref_sel,
	input  wire logic [1:0]  syn_loop_mask,
	input  wire logic [11:0] main_divide_count,
	input  wire logic [5:0]  swallow_count,
	input  wire logic [12:0] reference_divide_count,
	// what the chip holds
	output logic      [31:0] tot0,
	output logic      [31:0] tot1,
	output logic      [31:0] ref_div,
	output logic      [31:0] wr_cnt,
	output logic      [1:0]  last_mask,
	output logic             after_ref
);
	logic        last_ref; // previous strobe was a reference load
	logic [31:0] tot_in;   // total offered on the port
	assign tot_in = {14'h0, main_divide_count, swallow_count};
	// no back-pressure: every strobe lands
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			wr_cnt <= 32'h0;
			last_ref <= 1'b0;
		end else if (syn_wr) begin
			wr_cnt <= wr_cnt + 32'h1;
			last_ref <= syn_ref_sel;
			last_mask <= syn_loop_mask;
			if (syn_ref_sel) ref_div <= {19'h0, reference_divide_count};
			else after_ref <= last_ref;
			// loops take counts only on a main write
			if (!syn_ref_sel && syn_loop_mask[0]) tot0 <= tot_in;
			if (!syn_ref_sel && syn_loop_mask[1]) tot1 <= tot_in;
		end
	end
endmodule // synth_chip_model

// ---- test_synth_prog.sv ----
// bench for the divider programmer: bus calls with expected values
// assumes the chip model and the design package
`timescale 1ns/1ns
module test_synth_prog;
	typedef struct packed {
		logic [31:0] v; // request, 0 keeps
		logic [2:0]  c; // command
		logic [2:0]  e; // error code
		logic [1:0]  n; // chip writes
		logic [31:0] t; // loop 0 total
	} row_t;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic [1:0]  board_variant = 2'h0;
	logic [5:0]  address = 6'h0;
	logic        read = 1'b0;
	logic        write = 1'b0;
	logic [31:0] writedata = 32'h0;
	logic [31:0] readdata, tot0, tot1, ref_div, wr_cnt, q;
	logic [31:0] exp_wr = 32'h0; // writes expected so far
	logic        waitrequest, irq, syn_wr, syn_ref_sel, after_ref;
	logic [1:0]  syn_loop_mask, last_mask;
	logic [1:0]  msk = 2'h0;     // mask as written
	logic [11:0] main_divide_count;
	logic [5:0]  swallow_count;
	logic [12:0] reference_divide_count;
	int          error_cnt = 0;
	int          checks_done = 0;
	int          cycles = 0;
	row_t        tbl [12];
	synth_prog dut (
		.clk                    (clk),
		.rst_n                  (rst_n),
		.board_variant          (board_variant),
		.address                (address),
		.read                   (read),
		.write                  (write),
		.writedata              (writedata),
		.readdata               (readdata),
		.waitrequest            (waitrequest),
		.irq                    (irq),
		.syn_wr                 (syn_wr),
		.syn_ref_sel            (syn_ref_sel),
		.syn_loop_mask          (syn_loop_mask),
		.main_divide_count      (main_divide_count),
		.swallow_count          (swallow_count),
		.reference_divide_count (reference_divide_count)
	);
	synth_chip_model chip (
		.clk                    (clk),
		.rst_n                  (rst_n),
		.syn_wr                 (syn_wr),
		.syn_ref_sel            (syn_ref_sel),
		.syn_loop_mask          (syn_loop_mask),
		.main_divide_count      (main_divide_count),
		.swallow_count          (swallow_count),
		.reference_divide_count (reference_divide_count),
		.tot0                   (tot0),
		.tot1                   (tot1),
		.ref_div                (ref_div),
		.wr_cnt                 (wr_cnt),
		.last_mask              (last_mask),
		.after_ref              (after_ref)
	);
	// 100 MHz
	always #5 clk = ~clk;
	// hang guard, run needs under a thousand cycles
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			error_cnt++;
			conclude();
		end
	end
	// avalon access, held until waitrequest is sampled low at a rising edge
	task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d, output logic [31:0] r);
		@(posedge clk);
		read <= ~w;
		write <= w;
		address <= a;
		writedata <= d;
		@(posedge clk);
		while (waitrequest) @(posedge clk);
		// data and release at the completing edge only
		r = readdata;
		read <= 1'b0;
		write <= 1'b0;
	endtask
	task automatic wr(input logic [5:0] a, input logic [31:0] d);
		bus(1'b1, a, d, q);
	endtask
	// compare, count, report
	task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			error_cnt++;
			$display("[FAIL] %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic rd(input string nm, input logic [5:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0, q);
		check(nm, e, q);
	endtask
	// command, poll busy, judge status, writes, interrupt
	task automatic cmd(input logic [2:0] c, input logic [2:0] e, input logic [1:0] n);
		logic [31:0] s;
		wr(synth_prog_pkg::A_CMD, {29'h0, c});
		s = 32'h8;
		while (s[3]) bus(1'b0, synth_prog_pkg::A_STATUS, 32'h0, s);
		check("error", {29'h0, e}, {29'h0, s[2:0]});
		exp_wr = exp_wr + {30'h0, n};
		check("writes", exp_wr, wr_cnt);
		s = (e == 3'h0) ? 32'h1 : 32'h2;
		check("irq", {31'h0, |(s[1:0] & msk)}, {31'h0, irq});
		rd("irq status", synth_prog_pkg::A_IRQ_ST, s);
		// the clear lands on the read's completing edge; look one edge later
		@(posedge clk);
		check("irq clear", 32'h0, {31'h0, irq});
	endtask
	task automatic conclude();
		$display("checks %0d errors %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	// main sequence
	initial begin
		tbl = '{
			'{32'd640_000_000, 3'h6, 3'h0, 2'd1, 32'd6400},
			'{32'h0, 3'h5, 3'h0, 2'd1, 32'd6399},
			'{32'h0, 3'h4, 3'h0, 2'd1, 32'd6400},
			'{32'd640_050_000, 3'h6, 3'h1, 2'd0, 32'd6400},
			'{32'd10_000, 3'h7, 3'h0, 2'd2, 32'd64000},
			'{32'd2_621_440_000, 3'h6, 3'h3, 2'd0, 32'd64000},
			'{32'd2_621_430_000, 3'h6, 3'h0, 2'd1, 32'd262143},
			'{32'd40_310_000, 3'h6, 3'h2, 2'd0, 32'd262143},
			'{32'd40_000_000, 3'h6, 3'h0, 2'd1, 32'd4000},
			'{32'd2_010_000, 3'h7, 3'h4, 2'd0, 32'd4000},
			'{32'd1_600_000, 3'h7, 3'h6, 2'd0, 32'd4000},
			'{32'd1_000, 3'h7, 3'h5, 2'd0, 32'd4000}
		};
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		rd("ref", synth_prog_pkg::A_REF_CUR, 32'd14_400_000);
		rd("spacing", synth_prog_pkg::A_SP_CUR, 32'd100_000);
		wr(synth_prog_pkg::A_IRQ_MASK, 32'h2);
		msk = 2'h2;
		wr(synth_prog_pkg::A_PRE_LO, 32'd740_000_000);
		wr(synth_prog_pkg::A_PRE_LO, 32'h0);
		rd("low", synth_prog_pkg::A_PRE_LO, 32'd740_000_000);
		cmd(synth_prog_pkg::C_LOW, 3'h0, 2'd1);
		check("total", 32'd7400, tot0);
		wr(synth_prog_pkg::A_IRQ_MASK, 32'h3);
		msk = 2'h3;
		// spacing rows load SP_REQ, the rest FREQ_REQ
		foreach (tbl[i]) begin
			wr(tbl[i].c == 3'h7 ? synth_prog_pkg::A_SP_REQ : synth_prog_pkg::A_FREQ_REQ, tbl[i].v);
			cmd(tbl[i].c, tbl[i].e, tbl[i].n);
			check("total", tbl[i].t, tot0);
			check("main", tbl[i].t >> 6, {20'h0, main_divide_count});
			check("swallow", {26'h0, tbl[i].t[5:0]}, {26'h0, swallow_count});
			if (tbl[i].n == 2'd2) check("ref first", 32'h1, {31'h0, after_ref});
		end
		check("ref div", 32'd1440, ref_div);
		rd("spacing", synth_prog_pkg::A_SP_CUR, 32'd10_000);
		rd("out freq", synth_prog_pkg::A_OUT_FREQ, 32'd40_000_000);
		rd("counts", synth_prog_pkg::A_COUNTS, 32'd4000);
		rst_n <= 1'b0;
		board_variant <= synth_prog_pkg::V_DUAL;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		exp_wr = 32'h0;
		rd("low", synth_prog_pkg::A_PRE_LO, 32'd45_000_000);
		rd("mid", synth_prog_pkg::A_PRE_MD, 32'd60_000_000);
		rd("high", synth_prog_pkg::A_PRE_HI, 32'd75_000_000);
		wr(synth_prog_pkg::A_IRQ_MASK, 32'h3);
		wr(synth_prog_pkg::A_CTRL, 32'h3);
		cmd(synth_prog_pkg::C_HIGH, 3'h0, 2'd1);
		check("mask", 32'h2, {30'h0, last_mask});
		check("loop 1", 32'd7500, tot1);
		wr(synth_prog_pkg::A_CTRL, 32'h0);
		cmd(synth_prog_pkg::C_MED, 3'h0, 2'd1);
		check("mask", 32'h3, {30'h0, last_mask});
		check("loop 1", 32'd6000, tot1);
		wr(synth_prog_pkg::A_SP_REQ, 32'd1_010_000);
		cmd(synth_prog_pkg::C_REF, 3'h4, 2'd0);
		// wide-spacing single board defaults
		rst_n <= 1'b0;
		board_variant <= synth_prog_pkg::V_SINGLE_200K;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		rd("spacing", synth_prog_pkg::A_SP_CUR, 32'd200_000);
		rd("ref", synth_prog_pkg::A_REF_CUR, 32'd14_400_000);
		rd("status", synth_prog_pkg::A_STATUS, 32'h10);
		conclude();
	end
endmodule // test_synth_prog
